//--- dcb_store.sv
// configuration bit store: reset loader, table access, lock and option decode
module dcb_store #(
  parameter bit VOLATILE_FORM = 1'b1,
  parameter logic [23:0] FLASH_BASE = dcb_pkg::FLASH_CFG_BASE
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic tbl_valid,
  input wire dcb_pkg::dcb_tbl_req_s tbl_cmd,
  output logic tbl_ack,
  output logic [23:0] tbl_rdata,
  output logic flash_rd_req,
  output logic [23:0] flash_rd_addr,
  input wire logic [23:0] flash_rd_data,
  input wire logic flash_rd_valid,
  input wire logic last_page_erase,
  input wire logic upset_strobe,
  input wire logic [2:0] upset_sel,
  output logic cfg_ready,
  output logic prog_mem_lock,
  output logic config_mismatch_reset,
  output dcb_pkg::dcb_opts_s opts
);
  localparam int N = dcb_pkg::CFG_NUM;
  localparam int W = dcb_pkg::CFG_W;

  logic rst_s1_r;
  logic rst_s2_r;
  logic rst_n;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  assign rst_n = rst_s2_r;

  // reset loader
  dcb_pkg::dcb_load_e ld_st_r;
  dcb_pkg::dcb_load_e ld_st_nxt;
  logic [2:0] ld_idx_r;
  logic [2:0] ld_idx_nxt;
  logic [23:0] ld_addr_r;
  logic [23:0] ld_addr_nxt;
  logic ld_wr;

  always_comb begin
    ld_st_nxt = ld_st_r;
    ld_idx_nxt = ld_idx_r;
    ld_addr_nxt = ld_addr_r;
    ld_wr = 1'b0;
    case (ld_st_r)
      dcb_pkg::LD_START: begin
        ld_idx_nxt = 3'h0;
        ld_addr_nxt = FLASH_BASE;
        // the nonvolatile form keeps its cells and skips the copy
        ld_st_nxt = VOLATILE_FORM ? dcb_pkg::LD_REQ : dcb_pkg::LD_DONE;
      end
      dcb_pkg::LD_REQ: begin
        ld_st_nxt = dcb_pkg::LD_WAIT;
      end
      dcb_pkg::LD_WAIT: begin
        if (flash_rd_valid) begin
          ld_wr = 1'b1;
          if (ld_idx_r == dcb_pkg::LAST_IDX) begin
            ld_st_nxt = dcb_pkg::LD_DONE;
          end else begin
            ld_idx_nxt = ld_idx_r + 3'h1;
            ld_addr_nxt = ld_addr_r + dcb_pkg::FLASH_STRIDE;
            ld_st_nxt = dcb_pkg::LD_REQ;
          end
        end
      end
      dcb_pkg::LD_DONE: begin
        ld_st_nxt = dcb_pkg::LD_DONE;
      end
      default: begin
        ld_st_nxt = dcb_pkg::LD_START;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ld_st_r <= dcb_pkg::LD_START;
      ld_idx_r <= 3'h0;
      ld_addr_r <= 24'h000000;
    end else begin
      ld_st_r <= ld_st_nxt;
      ld_idx_r <= ld_idx_nxt;
      ld_addr_r <= ld_addr_nxt;
    end
  end

  assign cfg_ready = (ld_st_r == dcb_pkg::LD_DONE);
  assign flash_rd_req = (ld_st_r == dcb_pkg::LD_REQ);
  assign flash_rd_addr = ld_addr_r;

  // erase protection outlives reset: the erased page stays erased
  logic erase_prot_r = 1'b0;
  logic erase_prot_nxt;

  assign erase_prot_nxt = erase_prot_r | last_page_erase;

  always_ff @(posedge ref_clk) begin
    erase_prot_r <= erase_prot_nxt;
  end

  assign prog_mem_lock = erase_prot_r;

  // table access path
  dcb_pkg::dcb_tbl_e tb_st_r;
  dcb_pkg::dcb_tbl_e tb_st_nxt;
  logic [23:0] rdata_r;
  logic [23:0] rdata_nxt;
  logic hit_r;
  logic hit_nxt;
  logic take;
  logic tb_hit;
  logic tb_wr;
  logic [2:0] tb_idx;
  logic [N-1:0] lock_r;
  logic [N-1:0] lock_nxt;
  logic [W-1:0] mem_rd;
  logic mem_wr;
  logic [2:0] mem_wr_idx;
  logic [W-1:0] mem_wr_data;
  logic [N*W-1:0] cells;

  // requests wait while the loader runs, so software never sees stale bytes
  assign take = (tb_st_r == dcb_pkg::TB_IDLE) && tbl_valid && cfg_ready;
  assign tb_hit = dcb_pkg::cfg_hit(tbl_cmd.addr) && !erase_prot_r;
  assign tb_idx = dcb_pkg::cfg_index(tbl_cmd.addr);
  assign tb_wr = take && tbl_cmd.wr && tb_hit && (!VOLATILE_FORM || !lock_r[tb_idx]);

  always_comb begin
    tb_st_nxt = tb_st_r;
    rdata_nxt = rdata_r;
    hit_nxt = hit_r;
    case (tb_st_r)
      dcb_pkg::TB_IDLE: begin
        if (take) begin
          hit_nxt = tb_hit;
          tb_st_nxt = tbl_cmd.wr ? dcb_pkg::TB_ACK : dcb_pkg::TB_READ;
        end
      end
      dcb_pkg::TB_READ: begin
        rdata_nxt = hit_r ? {dcb_pkg::UNIMPL_HI, mem_rd} : 24'h000000;
        tb_st_nxt = dcb_pkg::TB_ACK;
      end
      dcb_pkg::TB_ACK: begin
        tb_st_nxt = dcb_pkg::TB_IDLE;
      end
      default: begin
        tb_st_nxt = dcb_pkg::TB_IDLE;
      end
    endcase
  end

  always_comb begin
    lock_nxt = lock_r;
    // only software writes lock; the loader fill does not count
    if (tb_wr && VOLATILE_FORM) begin
      lock_nxt[tb_idx] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tb_st_r <= dcb_pkg::TB_IDLE;
      rdata_r <= 24'h000000;
      hit_r <= 1'b0;
      lock_r <= '0;
    end else begin
      tb_st_r <= tb_st_nxt;
      rdata_r <= rdata_nxt;
      hit_r <= hit_nxt;
      lock_r <= lock_nxt;
    end
  end

  assign tbl_ack = (tb_st_r == dcb_pkg::TB_ACK);
  assign tbl_rdata = rdata_r;

  assign mem_wr = ld_wr | tb_wr;
  assign mem_wr_idx = ld_wr ? ld_idx_r : tb_idx;
  // upper two bytes of the flash word are not implemented
  assign mem_wr_data = ld_wr ? flash_rd_data[W-1:0] : tbl_cmd.wdata;

  dcb_cfg_mem #(
    .N(N),
    .W(W),
    .INIT(dcb_pkg::UNPROG_BYTE)
  ) u_mem (
    .clk(ref_clk),
    .wr_en(mem_wr),
    .wr_idx(mem_wr_idx),
    .wr_data(mem_wr_data),
    .rd_en(take && !tbl_cmd.wr),
    .rd_idx(tb_idx),
    .rd_data(mem_rd),
    .upset_en(upset_strobe),
    .upset_idx(upset_sel),
    .cells(cells)
  );

  dcb_cfg_check #(
    .N(N),
    .W(W),
    .INIT(dcb_pkg::UNPROG_BYTE)
  ) u_check (
    .clk(ref_clk),
    .rst_n(rst_n),
    .wr_en(mem_wr),
    .wr_idx(mem_wr_idx),
    .wr_data(mem_wr_data),
    .cells(cells),
    .armed(cfg_ready),
    .mismatch_rst(config_mismatch_reset)
  );

  // option decode
  logic [W-1:0] gp;
  logic [W-1:0] os;
  logic [W-1:0] oc;
  logic [W-1:0] wd;
  logic [W-1:0] rc;
  logic [W-1:0] db;
  dcb_pkg::dcb_opts_s opts_r;
  dcb_pkg::dcb_opts_s opts_nxt;
  dcb_pkg::dcb_posc_e posc;

  assign gp = cells[dcb_pkg::IDX_GEN_PROT*W +: W];
  assign os = cells[dcb_pkg::IDX_OSC_SEL*W +: W];
  assign oc = cells[dcb_pkg::IDX_OSC_CFG*W +: W];
  assign wd = cells[dcb_pkg::IDX_WDT_CFG*W +: W];
  assign rc = cells[dcb_pkg::IDX_RST_CFG*W +: W];
  assign db = cells[dcb_pkg::IDX_DBG_CFG*W +: W];
  assign posc = dcb_pkg::dcb_posc_e'(oc[dcb_pkg::OC_POSC_LSB +: 2]);

  always_comb begin
    opts_nxt = '0;
    // protection is on when its bit is programmed to 0
    opts_nxt.general_segment_protect_en = !gp[dcb_pkg::GP_GEN_BIT];
    opts_nxt.boot_segment_protect_en = !gp[dcb_pkg::GP_BOOT_BIT];
    opts_nxt.config_segment_protect_en = !gp[dcb_pkg::GP_CFG_BIT];
    opts_nxt.initial_osc_select = os[dcb_pkg::OS_INITIAL_OSC_SELECT_LSB +: 3];
    opts_nxt.two_speed_startup_en = os[dcb_pkg::OS_TWOSPD_BIT];
    opts_nxt.primary_osc_mode = posc;
    opts_nxt.osc_pin_function_sel = oc[dcb_pkg::OC_PINFN_BIT];
    // the pin is free for the clock only when no crystal sits on it
    opts_nxt.secondary_osc_pin_clock_out = oc[dcb_pkg::OC_PINFN_BIT] &&
      ((posc == dcb_pkg::POSC_EC) || (posc == dcb_pkg::POSC_OFF));
    opts_nxt.secondary_osc_power_sel = oc[dcb_pkg::OC_SOSC_BIT];
    opts_nxt.pin_mapping_lock = oc[dcb_pkg::OC_MAPLOCK_BIT];
    case (oc[dcb_pkg::OC_CKSM_LSB +: 2])
      2'h0: begin
        opts_nxt.clk_switch_en = 1'b1;
        opts_nxt.fail_safe_monitor_en = 1'b1;
      end
      2'h1: begin
        opts_nxt.clk_switch_en = 1'b1;
      end
      default: begin
        opts_nxt.clk_switch_en = 1'b0;
      end
    endcase
    opts_nxt.watchdog_enable = wd[dcb_pkg::WD_EN_BIT];
    opts_nxt.watchdog_prescale_sel = wd[dcb_pkg::WD_PRE_BIT];
    opts_nxt.wdt_prescale_ratio = wd[dcb_pkg::WD_PRE_BIT] ?
      dcb_pkg::WDT_PRE_RATIO_HI : dcb_pkg::WDT_PRE_RATIO_LO;
    opts_nxt.watchdog_postscale_sel = wd[dcb_pkg::WD_POST_LSB +: 4];
    opts_nxt.wdt_postscale_ratio = dcb_pkg::WDT_POST_UNIT << wd[dcb_pkg::WD_POST_LSB +: 4];
    opts_nxt.alt_regset_priority_assoc[0] = rc[dcb_pkg::RC_CTX1_LSB +: 3];
    opts_nxt.alt_regset_priority_assoc[1] = rc[dcb_pkg::RC_CTX2_LSB +: 3];
    opts_nxt.test_port_enable = db[dcb_pkg::DB_TEST_BIT];
    opts_nxt.test_pins_gpio_en = !db[dcb_pkg::DB_TEST_BIT];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      opts_r <= '0;
    end else begin
      opts_r <= opts_nxt;
    end
  end

  assign opts = opts_r;
endmodule : dcb_store

//--- dcb_pkg.sv
// constants, types and decode helpers of the configuration bit store
// Behaviour
// - volatile form reloads bytes from flash every reset
// - programmed bit reads 0, unprogrammed reads 1
// - volatile bytes take one write after load
// - flash word is three bytes, low byte used
// - last page erase locks program memory access
// - nonvolatile bytes persist yet stay reprogrammable
// - nonvolatile bytes reached only by table instructions
// - each register is one low byte
// - safety check upset raises mismatch reset
// - three-bit field picks default oscillator
// - watchdog enable, prescaler 1:128 or 1:32
// - watchdog postscaler from 1:1 to 1:32768
// - two-bit field picks primary oscillator mode
// - two-bit field picks switching and monitor combo
// - lock bit picks one-time or free remapping
// - test port enable takes pins from I/O
// - pin function bit picks I/O or clock output
// - three bits enable segment code protection
// - two-speed start-up and secondary oscillator power
// - fields tie alternate register sets to priorities
package dcb_pkg;
  localparam int CFG_NUM = 6;
  localparam int CFG_W = 8;
  localparam int CFG_IW = 3;
  localparam logic [23:0] ADDR_GEN_PROT = 24'hF80004;
  localparam logic [23:0] ADDR_OSC_SEL = 24'hF80006;
  localparam logic [23:0] ADDR_OSC_CFG = 24'hF80008;
  localparam logic [23:0] ADDR_WDT_CFG = 24'hF8000A;
  localparam logic [23:0] ADDR_RST_CFG = 24'hF8000C;
  localparam logic [23:0] ADDR_DBG_CFG = 24'hF8000E;
  localparam logic [23:0] FLASH_CFG_BASE = 24'h0057F0;
  localparam logic [23:0] FLASH_STRIDE = 24'h000002;
  localparam logic [7:0] UNPROG_BYTE = 8'hFF;
  localparam logic [15:0] UNIMPL_HI = 16'h0000;
  localparam logic [2:0] LAST_IDX = 3'h5;
  localparam int IDX_GEN_PROT = 0;
  localparam int IDX_OSC_SEL = 1;
  localparam int IDX_OSC_CFG = 2;
  localparam int IDX_WDT_CFG = 3;
  localparam int IDX_RST_CFG = 4;
  localparam int IDX_DBG_CFG = 5;
  localparam int GP_GEN_BIT = 0;
  localparam int GP_BOOT_BIT = 1;
  localparam int GP_CFG_BIT = 2;
  localparam int OS_INITIAL_OSC_SELECT_LSB = 0;
  localparam int OS_TWOSPD_BIT = 7;
  localparam int OC_POSC_LSB = 0;
  localparam int OC_PINFN_BIT = 2;
  localparam int OC_SOSC_BIT = 3;
  localparam int OC_MAPLOCK_BIT = 5;
  localparam int OC_CKSM_LSB = 6;
  localparam int WD_POST_LSB = 0;
  localparam int WD_PRE_BIT = 4;
  localparam int WD_EN_BIT = 7;
  localparam int RC_CTX1_LSB = 0;
  localparam int RC_CTX2_LSB = 4;
  localparam int DB_TEST_BIT = 5;
  localparam logic [7:0] WDT_PRE_RATIO_HI = 8'h80;
  localparam logic [7:0] WDT_PRE_RATIO_LO = 8'h20;
  localparam logic [15:0] WDT_POST_UNIT = 16'h0001;

  typedef enum logic [1:0] {POSC_EC, POSC_XT, POSC_HS, POSC_OFF} dcb_posc_e;
  typedef enum logic [1:0] {LD_START, LD_REQ, LD_WAIT, LD_DONE} dcb_load_e;
  typedef enum logic [1:0] {TB_IDLE, TB_READ, TB_ACK} dcb_tbl_e;

  typedef struct packed {
    logic wr;
    logic [23:0] addr;
    logic [7:0] wdata;
  } dcb_tbl_req_s;

  typedef struct packed {
    logic general_segment_protect_en;
    logic boot_segment_protect_en;
    logic config_segment_protect_en;
    logic [2:0] initial_osc_select;
    logic watchdog_enable;
    logic watchdog_prescale_sel;
    logic [7:0] wdt_prescale_ratio;
    logic [3:0] watchdog_postscale_sel;
    logic [15:0] wdt_postscale_ratio;
    logic two_speed_startup_en;
    logic pin_mapping_lock;
    logic test_port_enable;
    logic test_pins_gpio_en;
    logic osc_pin_function_sel;
    logic secondary_osc_pin_clock_out;
    dcb_posc_e primary_osc_mode;
    logic clk_switch_en;
    logic fail_safe_monitor_en;
    logic secondary_osc_power_sel;
    logic [1:0][2:0] alt_regset_priority_assoc;
  } dcb_opts_s;

  function automatic logic cfg_hit(input logic [23:0] addr);
    return (addr >= ADDR_GEN_PROT) && (addr <= ADDR_DBG_CFG) && !addr[0];
  endfunction : cfg_hit

  function automatic logic [2:0] cfg_index(input logic [23:0] addr);
    logic [23:0] diff;
    diff = addr - ADDR_GEN_PROT;
    return diff[3:1];
  endfunction : cfg_index
endpackage : dcb_pkg

//--- dcb_cfg_mem.sv
// storage cells of the configuration bytes with one registered read port
module dcb_cfg_mem #(
  parameter int N = dcb_pkg::CFG_NUM,
  parameter int W = dcb_pkg::CFG_W,
  parameter logic [W-1:0] INIT = dcb_pkg::UNPROG_BYTE
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [dcb_pkg::CFG_IW-1:0] wr_idx,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [dcb_pkg::CFG_IW-1:0] rd_idx,
  output logic [W-1:0] rd_data,
  input wire logic upset_en,
  input wire logic [dcb_pkg::CFG_IW-1:0] upset_idx,
  output logic [N*W-1:0] cells
);
  // no reset on purpose: contents must survive a device reset
  logic [N-1:0][W-1:0] cell_r = {N{INIT}};
  logic [N-1:0][W-1:0] cell_nxt;
  logic [W-1:0] rd_r = '0;
  logic [W-1:0] rd_nxt;

  always_comb begin
    cell_nxt = cell_r;
    rd_nxt = rd_r;
    if (wr_en && (wr_idx < N)) begin
      cell_nxt[wr_idx] = wr_data;
    end
    // disturbance hook: flips bit 0 so the safety check can see it
    if (upset_en && (upset_idx < N)) begin
      cell_nxt[upset_idx] = cell_nxt[upset_idx] ^ W'(1);
    end
    if (rd_en && (rd_idx < N)) begin
      rd_nxt = cell_r[rd_idx];
    end
  end

  always_ff @(posedge clk) begin
    cell_r <= cell_nxt;
    rd_r <= rd_nxt;
  end

  assign rd_data = rd_r;
  assign cells = cell_r;
endmodule : dcb_cfg_mem

//--- dcb_cfg_check.sv
// complement shadow of the configuration bytes and mismatch detector
module dcb_cfg_check #(
  parameter int N = dcb_pkg::CFG_NUM,
  parameter int W = dcb_pkg::CFG_W,
  parameter logic [W-1:0] INIT = dcb_pkg::UNPROG_BYTE
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [dcb_pkg::CFG_IW-1:0] wr_idx,
  input wire logic [W-1:0] wr_data,
  input wire logic [N*W-1:0] cells,
  input wire logic armed,
  output logic mismatch_rst
);
  // stored inverted so a stuck or flipped pair cannot agree by accident
  logic [N-1:0][W-1:0] inv_r = {N{~INIT}};
  logic [N-1:0][W-1:0] inv_nxt;
  logic miss_r, miss_nxt, pulse_r, pulse_nxt;

  always_comb begin
    inv_nxt = inv_r;
    if (wr_en && (wr_idx < N)) begin
      inv_nxt[wr_idx] = ~wr_data;
    end
    miss_nxt = armed && (cells != ~inv_r);
    pulse_nxt = miss_nxt && !miss_r;
  end

  always_ff @(posedge clk) begin
    inv_r <= inv_nxt;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      miss_r <= 1'b0;
      pulse_r <= 1'b0;
    end else begin
      miss_r <= miss_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign mismatch_rst = pulse_r;
endmodule : dcb_cfg_check

//--- dcb_flash_model.sv
// program flash model answering the loader's word reads, prompt or slow
module dcb_flash_model #(
  parameter logic [47:0] BYTES = 48'h0,
  parameter logic [23:0] BASE = 24'h0
) (
  input wire logic clk,
  input wire logic slow,
  input wire logic req,
  input wire logic [23:0] addr,
  output logic [23:0] data,
  output logic valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pend = 1'b0;
  int wait_cnt = 0;
  logic [23:0] word = 24'h0;
  logic [23:0] idx;
  initial begin
    data = 24'h0;
    valid = 1'b0;
  end
  assign idx = (addr - BASE) >> 1;
  always @(posedge clk) begin
    valid <= 1'b0;
    // idle port toggles so a stale word is never mistaken for fresh data
    data <= ~data;
    if (req) begin
      pend <= 1'b1;
      wait_cnt <= slow ? 4 : 0;
      // upper bytes carry filler the store has to drop
      word <= {16'hC35A, BYTES[8*idx[2:0] +: 8]};
    end else if (pend) begin
      if (wait_cnt == 0) begin
        valid <= 1'b1;
        data <= word;
        pend <= 1'b0;
      end else begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
endmodule : dcb_flash_model

//--- dcb_store_chk.sv
// port checks of the configuration store
module dcb_store_chk #(
  parameter bit VOLATILE_FORM = 1'b1,
  parameter logic [23:0] FLASH_BASE = dcb_pkg::FLASH_CFG_BASE
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic tbl_valid,
  input wire dcb_pkg::dcb_tbl_req_s tbl_cmd,
  input wire logic tbl_ack,
  input wire logic [23:0] tbl_rdata,
  input wire logic flash_rd_req,
  input wire logic [23:0] flash_rd_addr,
  input wire logic flash_rd_valid,
  input wire logic last_page_erase,
  input wire logic cfg_ready,
  input wire logic prog_mem_lock,
  input wire logic config_mismatch_reset,
  input wire logic upset_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_r;
  logic busy_nxt;
  logic [3:0] req_cnt_r;
  logic [3:0] req_cnt_nxt;
  logic take;
  logic mapped;
  // conservative take: a request held through the ack cycle is not counted
  assign take = tbl_valid && cfg_ready && !busy_r;
  assign mapped = (tbl_cmd.addr >= dcb_pkg::ADDR_GEN_PROT) && !tbl_cmd.addr[0]
    && (tbl_cmd.addr <= dcb_pkg::ADDR_DBG_CFG);
  always_comb begin
    busy_nxt = take ? 1'b1 : (tbl_ack ? 1'b0 : busy_r);
    req_cnt_nxt = flash_rd_req ? req_cnt_r + 4'h1 : req_cnt_r;
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busy_r <= 1'b0;
      req_cnt_r <= 4'h0;
    end else begin
      busy_r <= busy_nxt;
      req_cnt_r <= req_cnt_nxt;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  chk_write_ack_once: assert property (take && tbl_cmd.wr |=> tbl_ack ##1 !tbl_ack)
    else $error("write ack not one cycle after take");
  chk_read_ack_late: assert property (take && !tbl_cmd.wr |=> !tbl_ack ##1 tbl_ack)
    else $error("read ack not two cycles after take");
  chk_unmapped_zero: assert property (take && !tbl_cmd.wr && !mapped |-> ##2 tbl_rdata == 24'h0)
    else $error("unmapped read not zero");
  chk_upper_bytes: assert property (take && !tbl_cmd.wr |-> ##2 tbl_rdata[23:8] == 16'h0)
    else $error("upper read bytes not zero");
  chk_locked_read: assert property (take && !tbl_cmd.wr && prog_mem_lock |-> ##2 !tbl_rdata)
    else $error("read under protection not zero");
  chk_erase_locks: assert property (last_page_erase |=> prog_mem_lock [*3])
    else $error("erase did not lock program memory");
  chk_mismatch_pulse: assert property (config_mismatch_reset |=> !config_mismatch_reset)
    else $error("mismatch reset longer than one cycle");
  chk_mismatch_cause: assert property (config_mismatch_reset |-> !VOLATILE_FORM || $past(upset_strobe, 2))
    else $error("mismatch reset without upset");
  chk_flash_order: assert property (flash_rd_req |-> flash_rd_addr == FLASH_BASE + {19'h0, req_cnt_r, 1'b0})
    else $error("flash word address out of order");
  chk_ready_after: assert property (VOLATILE_FORM && flash_rd_valid && req_cnt_r == 4'h6 && !cfg_ready |=> cfg_ready)
    else $error("store not ready after sixth word");
  cov_write: cover property (take && tbl_cmd.wr);
  cov_mismatch: cover property (config_mismatch_reset);
  cov_locked: cover property (take && prog_mem_lock);
endmodule : dcb_store_chk

bind dcb_store dcb_store_chk #(.VOLATILE_FORM(VOLATILE_FORM), .FLASH_BASE(FLASH_BASE)) u_chk (
  .ref_clk(ref_clk), .rstn(rstn), .tbl_valid(tbl_valid), .tbl_cmd(tbl_cmd), .tbl_ack(tbl_ack),
  .tbl_rdata(tbl_rdata), .flash_rd_req(flash_rd_req), .flash_rd_addr(flash_rd_addr),
  .flash_rd_valid(flash_rd_valid), .last_page_erase(last_page_erase), .cfg_ready(cfg_ready),
  .prog_mem_lock(prog_mem_lock), .config_mismatch_reset(config_mismatch_reset),
  .upset_strobe(upset_strobe)
);

//--- dcb_store_tb_top.sv
// bench of the configuration store: volatile and nonvolatile forms
module dcb_store_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [47:0] LOAD = 48'hEF_53_9B_62_05_FA;
  localparam logic [23:0] OSC = dcb_pkg::ADDR_OSC_CFG;
  localparam logic [23:0] BAD [3] = '{24'hF80005, 24'hF80010, 24'hF80002};
  logic ref_clk, rstn, slow, tbl_valid, nv_valid, tbl_ack, nv_ack, cfg_ready, nv_ready;
  logic flash_rd_req, flash_rd_valid, last_page_erase, upset_strobe, prog_mem_lock;
  logic config_mismatch_reset, seen;
  logic [2:0] upset_sel;
  logic [23:0] tbl_rdata, nv_rdata, flash_rd_addr, flash_rd_data;
  dcb_pkg::dcb_tbl_req_s tbl_cmd;
  dcb_pkg::dcb_opts_s opts;
  int fails, num_checks;

  dcb_store #(.VOLATILE_FORM(1'b1), .FLASH_BASE(dcb_pkg::FLASH_CFG_BASE)) dut (
    .ref_clk(ref_clk), .rstn(rstn), .tbl_valid(tbl_valid), .tbl_cmd(tbl_cmd), .tbl_ack(tbl_ack),
    .tbl_rdata(tbl_rdata), .flash_rd_req(flash_rd_req), .flash_rd_addr(flash_rd_addr),
    .flash_rd_data(flash_rd_data), .flash_rd_valid(flash_rd_valid),
    .last_page_erase(last_page_erase), .upset_strobe(upset_strobe), .upset_sel(upset_sel),
    .cfg_ready(cfg_ready), .prog_mem_lock(prog_mem_lock),
    .config_mismatch_reset(config_mismatch_reset), .opts(opts));
  // second store in nonvolatile form; its loader never waits, so shared flash traffic is ignored
  dcb_store #(.VOLATILE_FORM(1'b0)) nvd (
    .ref_clk(ref_clk), .rstn(rstn), .tbl_valid(nv_valid), .tbl_cmd(tbl_cmd), .tbl_ack(nv_ack),
    .tbl_rdata(nv_rdata), .flash_rd_req(), .flash_rd_addr(), .flash_rd_data(flash_rd_data),
    .flash_rd_valid(flash_rd_valid), .last_page_erase(last_page_erase), .upset_strobe(1'b0),
    .upset_sel(upset_sel), .cfg_ready(nv_ready), .prog_mem_lock(), .config_mismatch_reset(),
    .opts());
  dcb_flash_model #(.BYTES(LOAD), .BASE(dcb_pkg::FLASH_CFG_BASE)) flash (
    .clk(ref_clk), .slow(slow), .req(flash_rd_req), .addr(flash_rd_addr),
    .data(flash_rd_data), .valid(flash_rd_valid));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // entered just after a rising edge; request held until the edge that samples the ack
  task automatic tbl_op(input bit nv, input logic wr, input logic [23:0] a,
      input logic [7:0] d, output logic [23:0] rd);
    int n;
    n = 0;
    tbl_cmd <= {wr, a, d};
    if (nv) nv_valid <= 1'b1;
    else tbl_valid <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!(nv ? nv_ack : tbl_ack) && n < 300);
    rd = nv ? nv_rdata : tbl_rdata;
    tbl_valid <= 1'b0;
    nv_valid <= 1'b0;
    if (n >= 300) begin
      fails++;
      $display("ERROR %0t: no table ack", $time);
    end
    // one idle edge so a following call never raises valid in the step that dropped it
    @(posedge ref_clk);
  endtask : tbl_op

  task automatic wr(input bit nv, input logic [23:0] a, input logic [7:0] d);
    logic [23:0] rd;
    tbl_op(nv, 1'b1, a, d, rd);
  endtask : wr

  task automatic rchk(input bit nv, input logic [23:0] a, input logic [23:0] exp);
    logic [23:0] rd;
    tbl_op(nv, 1'b0, a, 8'h00, rd);
    check(rd, exp);
  endtask : rchk

  task automatic do_reset(input logic slow_mode);
    int n;
    n = 0;
    rstn <= 1'b0;
    slow <= slow_mode;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!cfg_ready && n < 300);
    check(cfg_ready, 1'b1);
    @(posedge ref_clk);
  endtask : do_reset

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    $display("ERROR %0t: run timed out", $time);
    final_report;
  end

  initial begin
    rstn = 1'b0;
    slow = 1'b0;
    tbl_valid = 1'b0;
    nv_valid = 1'b0;
    tbl_cmd = '0;
    last_page_erase = 1'b0;
    upset_strobe = 1'b0;
    upset_sel = 3'h0;
    fails = 0;
    num_checks = 0;
    seen = 1'b0;
    @(posedge ref_clk);
    do_reset(1'b0);
    for (int i = 0; i < 6; i++) begin
      rchk(1'b0, dcb_pkg::ADDR_GEN_PROT + 24'(2 * i), {16'h0, LOAD[8*i +: 8]});
    end
    check({opts.general_segment_protect_en, opts.boot_segment_protect_en}, 2'h2);
    check(opts.config_segment_protect_en, 1'b1);
    check({opts.initial_osc_select, opts.two_speed_startup_en}, 4'hA);
    check({opts.primary_osc_mode, opts.pin_mapping_lock}, 3'h5);
    check({opts.clk_switch_en, opts.fail_safe_monitor_en}, 2'h2);
    check({opts.watchdog_enable, opts.watchdog_prescale_sel, opts.wdt_prescale_ratio}, 10'h380);
    check({opts.watchdog_postscale_sel, opts.wdt_postscale_ratio}, 20'hB0800);
    check(opts.alt_regset_priority_assoc, 6'h2B);
    check({opts.test_port_enable, opts.test_pins_gpio_en}, 2'h2);
    foreach (BAD[i]) rchk(1'b0, BAD[i], 24'h0);
    wr(1'b0, OSC, 8'h3F);
    rchk(1'b0, OSC, 24'h3F);
    check({opts.primary_osc_mode, opts.osc_pin_function_sel, opts.secondary_osc_pin_clock_out}, 4'hF);
    check({opts.secondary_osc_power_sel, opts.clk_switch_en, opts.fail_safe_monitor_en}, 3'h7);
    wr(1'b0, OSC, 8'h00);
    rchk(1'b0, OSC, 24'h3F);
    wr(1'b1, OSC, 8'h11);
    wr(1'b1, OSC, 8'h22);
    rchk(1'b1, OSC, 24'h22);
    upset_sel <= 3'h2;
    upset_strobe <= 1'b1;
    @(posedge ref_clk);
    upset_strobe <= 1'b0;
    repeat (4) begin
      @(posedge ref_clk);
      seen = seen | config_mismatch_reset;
    end
    check(seen, 1'b1);
    do_reset(1'b1);
    rchk(1'b0, OSC, 24'h62);
    wr(1'b0, OSC, 8'h7C);
    rchk(1'b0, OSC, 24'h7C);
    rchk(1'b1, OSC, 24'h22);
    last_page_erase <= 1'b1;
    @(posedge ref_clk);
    last_page_erase <= 1'b0;
    @(posedge ref_clk);
    check(prog_mem_lock, 1'b1);
    wr(1'b1, OSC, 8'h33);
    rchk(1'b1, OSC, 24'h0);
    rchk(1'b0, dcb_pkg::ADDR_WDT_CFG, 24'h0);
    final_report;
  end
endmodule : dcb_store_tb_top
